// >>> verilog/irc_top.sv
// Purpose: four iso receive context controls behind a classic Wishbone slave
// Assumes: software keeps option bits stable while running; link words are in the clk domain
// Notes: ack is registered, one wait state; unmapped reads return zero with ack
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "irc_regs.svh"
module irc_top
  import irc_pkg::*;
#(
  parameter int N_CTX = 4
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] ctx_channel [N_CTX],
  input wire logic [63:0] chan_mask,
  input wire logic cs_valid,
  input wire logic [12:0] cs_count,
  input wire logic [15:0] cs_stamp,
  input wire logic pk_valid,
  input wire logic pk_first,
  input wire logic pk_last,
  input wire logic [5:0] pk_chan,
  input wire logic [31:0] pk_data,
  input wire logic [15:0] pk_status,
  input wire logic [N_CTX-1:0] buf_full,
  output logic [N_CTX-1:0] st_valid,
  output logic [31:0] st_data [N_CTX],
  output irc_kind_t st_kind [N_CTX],
  output logic [N_CTX-1:0] st_buf_end
);
  import irc_pkg::*;

  // The context index decode is only two bits wide
  if (N_CTX < 1 || N_CTX > 4) begin : g_bad_ctx
    $error("N_CTX must be 1 to 4");
  end

  logic [31:0] ctrl_ff [N_CTX];
  logic [12:0] start_cycle_value_ff [N_CTX];
  logic [31:0] rd_word;
  logic wr_set;
  logic wr_clr;
  logic [1:0] hit_ctx;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // Aliases sit at base + 32*n; bits 4:0 pick set or clear
  always_comb begin
    hit_ctx = 2'd0;
    wr_set = 1'b0;
    wr_clr = 1'b0;
    for (int i = 0; i < N_CTX; i++) begin
      if (wb_adr_i == `IRC_SET_BASE + 12'(i) * `IRC_STRIDE) begin
        hit_ctx = 2'(i);
        wr_set = 1'b1;
      end
      if (wb_adr_i == `IRC_CLR_BASE + 12'(i) * `IRC_STRIDE) begin
        hit_ctx = 2'(i);
        wr_clr = 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_CTX; g++) begin : g_ctx
      irc_ctx_if cif ();
      logic do_set;
      logic do_clr;
      logic [31:0] wmask;

      assign do_set = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wr_set && hit_ctx == 2'(g);
      assign do_clr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wr_clr && hit_ctx == 2'(g);
      assign wmask = wb_dat_i & lane_mask(wb_sel_i) & `IRC_SW_MASK;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ctrl_ff[g] <= `IRC_CTRL_RESET;
        end else begin
          ctrl_ff[g][31:28] <= (ctrl_ff[g][31:28] | (do_set ? wmask[31:28] : 4'h0))
                               & ~(do_clr ? wmask[31:28] : 4'h0);
          // Hardware clear of the start enable wins over a software set in the same cycle
          if (cif.cyc_clr)
            ctrl_ff[g][`IRC_BIT_CYC_EN] <= 1'b0;
          ctrl_ff[g][`IRC_BIT_RUN] <= (ctrl_ff[g][`IRC_BIT_RUN] | (do_set && wmask[`IRC_BIT_RUN]))
                                      & ~(do_clr && wmask[`IRC_BIT_RUN]);
          // A software wake wins over the engine's clear
          if (do_set && wmask[`IRC_BIT_WAKE])
            ctrl_ff[g][`IRC_BIT_WAKE] <= 1'b1;
          else if (cif.wake_clr || (do_clr && wmask[`IRC_BIT_WAKE]))
            ctrl_ff[g][`IRC_BIT_WAKE] <= 1'b0;
          ctrl_ff[g][`IRC_BIT_DEAD] <= cif.dead;
          ctrl_ff[g][`IRC_BIT_ACTIVE] <= cif.active;
          ctrl_ff[g][9:0] <= 10'h000;
          ctrl_ff[g][14:13] <= 2'b00;
          ctrl_ff[g][27:16] <= 12'h000;
        end
      end

      // Start cycle value comes from the companion register at base+8
      assign cif.run = ctrl_ff[g][`IRC_BIT_RUN];
      assign cif.wake = ctrl_ff[g][`IRC_BIT_WAKE];
      assign cif.pack = ctrl_ff[g][`IRC_BIT_PACK];
      assign cif.keep = ctrl_ff[g][`IRC_BIT_KEEP];
      assign cif.cyc_en = ctrl_ff[g][`IRC_BIT_CYC_EN];
      assign cif.allch = ctrl_ff[g][`IRC_BIT_ALLCH];
      assign cif.cyc_val = start_cycle_value_ff[g];

      irc_ctx_engine u_eng (
        .clk(clk),
        .rstn(rstn),
        .ctl(cif),
        .my_channel(ctx_channel[g]),
        .chan_mask(chan_mask),
        .cs_valid(cs_valid),
        .cs_count(cs_count),
        .cs_stamp(cs_stamp),
        .pk_valid(pk_valid),
        .pk_first(pk_first),
        .pk_last(pk_last),
        .pk_chan(pk_chan),
        .pk_data(pk_data),
        .pk_status(pk_status),
        .buf_full(buf_full[g]),
        .st_valid(st_valid[g]),
        .st_data(st_data[g]),
        .st_kind(st_kind[g]),
        .st_buf_end(st_buf_end[g])
      );
    end
  endgenerate

  // Start cycle values: a small companion register per context at base+8
  generate
    for (g = 0; g < N_CTX; g++) begin : g_cyc
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
          start_cycle_value_ff[g] <= 13'h0000;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                 && wb_adr_i == `IRC_SET_BASE + 12'h008 + 12'(g) * `IRC_STRIDE)
          start_cycle_value_ff[g] <= wb_dat_i[`IRC_CYC_LSB +: `IRC_CYC_W];
      end
    end
  endgenerate

  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < N_CTX; i++) begin
      if (wb_adr_i == `IRC_SET_BASE + 12'(i) * `IRC_STRIDE
          || wb_adr_i == `IRC_CLR_BASE + 12'(i) * `IRC_STRIDE)
        rd_word = ctrl_ff[i];
      if (wb_adr_i == `IRC_SET_BASE + 12'h008 + 12'(i) * `IRC_STRIDE)
        rd_word = {19'h00000, start_cycle_value_ff[i]} << `IRC_CYC_LSB;
    end
  end

  // Registered ack: one wait state, dropped the cycle after it is given
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
        wb_dat_o <= rd_word;
    end
  end
endmodule : irc_top
`default_nettype wire

// >>> pkg/irc_regs.svh
// Purpose: register offsets, field positions and reset values for the iso receive controls
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes: four contexts, set alias and clear alias per context
// Summary of operation
// - There are four receive contexts, zero to three, each with its own control register.
// - Each control register has a set alias at 400h and a clear alias at 404h, 32 bytes apart.
// - After reset bits 26 to 13 and 11 to 8 read zero.
// - With pack_buffers set, packets are packed back to back to fill each buffer.
// - With pack_buffers clear, each packet goes to a buffer of its own.
// - With keep_packet_header set, each stored packet keeps its received header.
// - With headers kept, a trailer ends each packet with transfer_result and a 16-bit timestamp.
// - With keep_packet_header clear, the header is stripped before storing.
// - With start_on_cycle_enable set, the context starts when start_cycle_value equals a cycle count.
// - Hardware clears start_on_cycle_enable once the context is active.
// - With all_channel_receive set, packets on every channel enabled in the mask are taken.
// - In all-channel operation the single channel of the match register is ignored.
// - The active bit is set while the context processes descriptors.
`ifndef IRC_REGS_SVH
`define IRC_REGS_SVH
`define IRC_SET_BASE 12'h400
`define IRC_CLR_BASE 12'h404
`define IRC_STRIDE 12'h020
`define IRC_BIT_PACK 31
`define IRC_BIT_KEEP 30
`define IRC_BIT_CYC_EN 29
`define IRC_BIT_ALLCH 28
`define IRC_BIT_RUN 15
`define IRC_BIT_WAKE 12
`define IRC_BIT_DEAD 11
`define IRC_BIT_ACTIVE 10
`define IRC_CYC_LSB 12
`define IRC_CYC_W 13
`define IRC_SW_MASK 32'hf000_9000
`define IRC_CTRL_RESET 32'h0000_0000
`define IRC_HDR_W 32
`endif

// >>> pkg/irc_pkg.sv
package irc_pkg;
  typedef enum logic [1:0] {IRC_IDLE, IRC_WAIT_CYCLE, IRC_ACTIVE} irc_state_t;
  typedef enum logic [1:0] {IRC_OUT_NONE, IRC_OUT_HEADER, IRC_OUT_DATA, IRC_OUT_TRAILER} irc_kind_t;
endpackage : irc_pkg

// >>> pkg/irc_ctx_if.sv
// Purpose: per-context control signals between register file and context engine
// Assumes: one clock
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface irc_ctx_if;
  logic run;
  logic wake;
  logic pack;
  logic keep;
  logic cyc_en;
  logic allch;
  logic [12:0] cyc_val;
  logic active;
  logic dead;
  logic cyc_clr;
  logic wake_clr;
  modport regs (output run, wake, pack, keep, cyc_en, allch, cyc_val, input active, dead, cyc_clr,
                wake_clr);
  modport eng (input run, wake, pack, keep, cyc_en, allch, cyc_val, output active, dead, cyc_clr,
               wake_clr);
endinterface : irc_ctx_if
`default_nettype wire

// >>> verilog/irc_ctx_engine.sv
// Purpose: one receive context: start control, channel filter, header strip, packing
// Assumes: link words arrive tagged with first and last flags, one per cycle
// Notes: descriptor fetch is outside; buffer end is signalled by buf_full
`timescale 1ns/10ps
`default_nettype none
`include "irc_regs.svh"
module irc_ctx_engine
  import irc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  irc_ctx_if.eng ctl,
  input wire logic [5:0] my_channel,
  input wire logic [63:0] chan_mask,
  input wire logic cs_valid,
  input wire logic [12:0] cs_count,
  input wire logic [15:0] cs_stamp,
  input wire logic pk_valid,
  input wire logic pk_first,
  input wire logic pk_last,
  input wire logic [5:0] pk_chan,
  input wire logic [31:0] pk_data,
  input wire logic [15:0] pk_status,
  input wire logic buf_full,
  output logic st_valid,
  output logic [31:0] st_data,
  output irc_kind_t st_kind,
  output logic st_buf_end
);
  irc_state_t state_ff;
  logic [15:0] stamp_ff;
  logic take_ff;
  logic tail_ff;
  logic [15:0] tail_stat_ff;
  logic accept;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= IRC_IDLE;
    end else begin
      case (state_ff)
        IRC_IDLE: begin
          if (ctl.run)
            state_ff <= ctl.cyc_en ? IRC_WAIT_CYCLE : IRC_ACTIVE;
        end
        IRC_WAIT_CYCLE: begin
          if (!ctl.run)
            state_ff <= IRC_IDLE;
          else if (cs_valid && cs_count == ctl.cyc_val)
            state_ff <= IRC_ACTIVE;
        end
        IRC_ACTIVE: begin
          if (!ctl.run)
            state_ff <= IRC_IDLE;
        end
        default: state_ff <= IRC_IDLE;
      endcase
    end
  end

  assign ctl.active = (state_ff == IRC_ACTIVE);
  assign ctl.cyc_clr = (state_ff == IRC_ACTIVE) && ctl.cyc_en;
  assign ctl.dead = 1'b0;
  assign ctl.wake_clr = ctl.active && ctl.wake;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      stamp_ff <= 16'h0000;
    else if (cs_valid)
      stamp_ff <= cs_stamp;
  end

  // All-channel mode looks only at the mask, never at the context's own channel
  assign accept = ctl.allch ? chan_mask[pk_chan] : (pk_chan == my_channel);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      take_ff <= 1'b0;
    else if (pk_valid && pk_first)
      take_ff <= ctl.active && accept && !pk_last;
    else if (pk_valid && pk_last)
      take_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_valid <= 1'b0;
      st_data <= 32'h0000_0000;
      st_kind <= IRC_OUT_NONE;
      st_buf_end <= 1'b0;
      tail_ff <= 1'b0;
      tail_stat_ff <= 16'h0000;
    end else begin
      st_valid <= 1'b0;
      st_kind <= IRC_OUT_NONE;
      st_buf_end <= 1'b0;
      tail_ff <= 1'b0;
      if (tail_ff) begin
        st_valid <= 1'b1;
        st_kind <= IRC_OUT_TRAILER;
        st_data <= {tail_stat_ff, stamp_ff};
        st_buf_end <= !ctl.pack || buf_full;
      end else if (pk_valid && ((pk_first && ctl.active && accept) || (!pk_first && take_ff))) begin
        if (pk_first && !ctl.keep) begin
          st_valid <= 1'b0;
        end else begin
          st_valid <= 1'b1;
          st_kind <= pk_first ? IRC_OUT_HEADER : IRC_OUT_DATA;
          st_data <= pk_data;
        end
        if (pk_last) begin
          if (ctl.keep) begin
            tail_ff <= 1'b1;
            tail_stat_ff <= pk_status;
          end else begin
            // One packet per buffer unless packing; packing closes only on a full buffer
            st_buf_end <= !ctl.pack || buf_full;
          end
        end
      end
    end
  end
endmodule : irc_ctx_engine
`default_nettype wire

// >>> bench/irc_top_assertions.sv
// Purpose: port checks for the iso receive controls
// Assumes: one clock, active-low reset
// Notes: datapath checks watch context 0
`timescale 1ns/10ps
`default_nettype none
module irc_top_assertions
  import irc_pkg::*;
#(
  parameter int N_CTX = 4
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pk_valid,
  input wire logic pk_first,
  input wire logic [31:0] pk_data,
  input wire logic [N_CTX-1:0] st_valid,
  input wire logic [31:0] st_data [N_CTX],
  input wire irc_kind_t st_kind [N_CTX]
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic req, hole;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Only set, clear and start words of contexts 0 to 3 decode
  assign hole = wb_adr_i[11:7] != 5'h08 || !(wb_adr_i[4:0] inside {5'h00, 5'h04, 5'h08});
  a_ack_one_wait: assert property (req |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_has_req: assert property (wb_ack_o |-> $past(req))
    else $error("stray ack");
  a_hole_reads_zero: assert property (req && !wb_we_i && hole |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_header_kept: assert property (st_valid[0] && st_kind[0] == IRC_OUT_HEADER |->
    $past(pk_valid) && $past(pk_first) && st_data[0] == $past(pk_data)) else $error("bad header");
  a_data_copy: assert property (st_valid[0] && st_kind[0] == IRC_OUT_DATA |->
    $past(pk_valid) && !$past(pk_first) && st_data[0] == $past(pk_data)) else $error("bad data");
  a_trailer_follows: assert property (st_valid[0] && st_kind[0] == IRC_OUT_TRAILER |->
    $past(st_valid[0])) else $error("lone trailer");
  a_silent_idle: assert property (!$past(pk_valid) && !$past(st_valid[0]) |->
    !st_valid[0]) else $error("output without traffic");
endmodule : irc_top_assertions
bind irc_top irc_top_assertions #(.N_CTX(N_CTX)) u_chk (.*);
`default_nettype wire

// >>> bench/irc_link_model.sv
// Purpose: link layer stand-in for cycle starts and packet words
// Assumes: driven just after the rising edge, one word per cycle
// Notes: idle data and status lines flip each cycle so stale values never pass for data
`timescale 1ns/10ps
`default_nettype none
module irc_link_model (
  input wire logic clk,
  output logic cs_valid,
  output logic [12:0] cs_count,
  output logic [15:0] cs_stamp,
  output logic pk_valid,
  output logic pk_first,
  output logic pk_last,
  output logic [5:0] pk_chan,
  output logic [31:0] pk_data,
  output logic [15:0] pk_status
);
  logic busy = 1'b0;
  initial {cs_valid, cs_count, cs_stamp, pk_valid, pk_first, pk_last, pk_chan, pk_data} = '0;
  initial pk_status = 16'h0;
  always @(posedge clk) if (!busy) {pk_data, pk_status} <= ~{pk_data, pk_status};
  task automatic cycle_start(input logic [12:0] c);
    busy = 1'b1;
    @(posedge clk);
    {cs_valid, cs_count, cs_stamp} <= {1'b1, c, 3'h0, c};
    @(posedge clk);
    cs_valid <= 1'b0;
    busy = 1'b0;
  endtask : cycle_start
  task automatic packet(input logic [5:0] ch, input int w);
    busy = 1'b1;
    for (int i = 0; i < w; i++) begin
      @(posedge clk);
      {pk_valid, pk_first, pk_last, pk_chan} <= {1'b1, (i == 0), (i == w - 1), ch};
      {pk_data, pk_status} <= {32'hd000_0000 + 32'(i), 16'h0011};
    end
    @(posedge clk);
    pk_valid <= 1'b0;
    busy = 1'b0;
  endtask : packet
endmodule : irc_link_model
`default_nettype wire

// >>> bench/irc_top_tb.sv
// Purpose: self-checking bench for the iso receive controls
// Assumes: one wait state on the bus; link words one per cycle
// Notes: traffic runs on context 0; the rest are checked by register
`timescale 1ns/10ps
`default_nettype none
module irc_top_tb;
  import irc_pkg::*;
  logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cs_valid, pk_valid, pk_first, pk_last;
  logic [3:0] wb_sel_i, buf_full, st_valid, st_buf_end;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, pk_data, rd, tr;
  logic [31:0] st_data [4];
  logic [12:0] cs_count;
  logic [15:0] cs_stamp, pk_status;
  logic [5:0] pk_chan;
  logic [5:0] ctx_channel [4];
  logic [63:0] chan_mask;
  irc_kind_t st_kind [4];
  int bad_count, check_count;
  int n_k [4];
  int n_end;
  irc_top #(.N_CTX(4)) uut (.*);
  irc_link_model u_link (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (st_valid[0])
      n_k[st_kind[0]]++;
    if (st_buf_end[0])
      n_end++;
    if (st_valid[0] && st_kind[0] == IRC_OUT_TRAILER)
      tr = st_data[0];
  end
  function automatic logic [11:0] ra(input int n, input int off);
    return 12'h400 + 12'(32 * n + off);
  endfunction : ra
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic bound(input int n);
    if (n >= 20) begin
      bad_count++;
      report_and_stop();
    end
  endtask : bound
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    bound(n);
  endtask : wb
  // Counts of buffer ends, header, data and trailer words seen on context 0
  task automatic pkt(input logic [5:0] ch, input logic [31:0] exp);
    n_k = '{default: 0};
    n_end = 0;
    u_link.packet(ch, 3);
    repeat (3) @(posedge clk);
    chk({8'(n_end), 8'(n_k[1]), 8'(n_k[2]), 8'(n_k[3])}, exp);
  endtask : pkt
  // Options are only touched once the context reads idle
  task automatic stop_ctx();
    int n = 0;
    wb(1'b1, ra(0, 4), 32'h0000_8000);
    do wb(1'b0, ra(0, 0), 32'h0); while (rd[10] !== 1'b0 && ++n < 20);
    bound(n);
    wb(1'b1, ra(0, 4), 32'hf000_0000);
  endtask : stop_ctx
  task automatic t_regs();
    logic [31:0] pat [4];
    pat = '{32'h9000_0000, 32'h4000_0000, 32'h2000_0000, 32'h8000_1000};
    for (int n = 0; n < 4; n++) begin
      wb(1'b0, ra(n, 4), 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, ra(n, 0), pat[n]);
    end
    for (int n = 0; n < 4; n++) begin
      wb(1'b0, ra(n, 4), 32'h0);
      chk(rd, pat[n]);
      wb(1'b1, ra(n, 4), 32'hffff_ffff);
      wb(1'b0, ra(n, 0), 32'h0);
      chk(rd, 32'h0);
    end
    wb_sel_i <= 4'h7;
    wb(1'b1, ra(1, 0), 32'hffff_6fff);
    wb_sel_i <= 4'hf;
    wb(1'b0, ra(1, 0), 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 12'h40c, 32'hffff_ffff);
    wb(1'b0, 12'h40c, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
  endtask : t_regs
  task automatic t_traffic();
    wb(1'b1, ra(0, 0), 32'h0000_8000);
    wb(1'b0, ra(0, 0), 32'h0);
    chk(rd & 32'h0000_0400, 32'h0000_0400);
    pkt(6'd1, 32'h0100_0200);
    stop_ctx();
    u_link.cycle_start(13'h0123);
    wb(1'b1, ra(0, 0), 32'h4000_8000);
    pkt(6'd1, 32'h0101_0201);
    chk(tr, 32'h0011_0123);
    stop_ctx();
    $display("traffic test done");
  endtask : t_traffic
  task automatic t_start();
    wb(1'b1, ra(0, 8), 32'h0000_5000);
    wb(1'b0, ra(0, 8), 32'h0);
    chk(rd, 32'h0000_5000);
    wb(1'b1, ra(0, 0), 32'h2000_8000);
    u_link.cycle_start(13'd4);
    pkt(6'd1, 32'h0);
    u_link.cycle_start(13'd5);
    pkt(6'd1, 32'h0100_0200);
    wb(1'b0, ra(0, 0), 32'h0);
    chk(rd & 32'h2000_0400, 32'h0000_0400);
    stop_ctx();
    chan_mask <= 64'h80;
    wb(1'b1, ra(0, 0), 32'h9000_8000);
    pkt(6'd7, 32'h0000_0200);
    buf_full <= 4'h1;
    pkt(6'd7, 32'h0100_0200);
    buf_full <= 4'h0;
    pkt(6'd1, 32'h0);
    stop_ctx();
    $display("start test done");
  endtask : t_start
  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, chan_mask} = '0;
    wb_sel_i = 4'hf;
    buf_full = 4'h0;
    ctx_channel = '{6'd1, 6'd2, 6'd3, 6'd4};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_traffic();
    t_start();
    report_and_stop();
  end
endmodule : irc_top_tb
`default_nettype wire
